// [nvm_ctrl_defs.svh]
/*
 * Offsets, field positions, reset values and timing counts of the data flash controller.
 * Assumes inclusion by its bare name from the design file, the CPU model and the bench.
 */
`ifndef NVM_CTRL_DEFS_SVH
`define NVM_CTRL_DEFS_SVH

`define OFS_FLASH_ADDRESS   16'h1c8c
`define OFS_FLASH_DATA      16'h1c8e
`define OFS_FLASH_CONTROL   16'h1c90
`define OFS_UNLOCK_REGISTER 16'h1c91
`define OFS_FLASH_STATUS    16'h1c94
// Register index; the byte address on the bus is four times the index
`define ADDR_FLASH_ADDRESS  14'h1c8c
`define ADDR_FLASH_DATA     14'h1c8e
`define ADDR_FLASH_CONTROL  14'h1c90
`define ADDR_UNLOCK_REG     14'h1c91
`define ADDR_FLASH_STATUS   14'h1c94
`define BIT_RD              0
`define BIT_WR              1
`define BIT_PROGRAM_ERASE_ENABLE            2
`define BIT_WRITE_ERROR_FLAG           3
`define BIT_FREE            4
`define BIT_LATCH_ONLY            5
`define BIT_REGS            6
`define BIT_COMPLETION_FLAG           0
`define BIT_COMPLETION_IRQ_ENABLE           1
`define RESET_ADDRESS       16'h0000
`define RESET_CONTROL       8'h00
`define UNLOCK_FIRST        8'h55
`define UNLOCK_SECOND       8'haa
`define DFM_NIBBLE          4'h7
`define DFM_REGS_PAGE       8'hf0
`define PROG_TIME_NS        10000
`define CLK_PERIOD_NS       5
`define PROG_CYCLES         ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define UNLOCK_WINDOW       4

`endif

// [nvm_ctrl_pkg.sv]
/*
 * Types shared by the data flash controller.
 * Assumes the defines header is available on the include path.
 */
package nvm_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_PROG = 2'b10
    } nvm_state_t;

    typedef enum logic [1:0] {
        UL_NONE  = 2'b00,
        UL_FIRST = 2'b01,
        UL_ARMED = 2'b10
    } unlock_state_t;

    typedef struct packed {
        logic        regs;
        logic        latch_only;
        logic        free;
        logic        write_error_flag;
        logic        program_erase_enable;
        logic        wr;
        logic        rd;
    } control_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
    } ptr_req_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  data;
    } ptr_rsp_t;
endpackage

// [nvm_ctrl.sv]
/*
 * Data flash controller: AHB-Lite register slave, unlock detector, read, self-timed
 * write and indirect read-only pointer path over a flip-flop data flash array.
 * Assumes one clock, a single AHB master with word transfers, and a CPU that honours stall.
 */
// Summary of operation
// [R1] Flash accessed one byte per operation: low data byte, address register pair.
// [R2] Byte write erases then programs; length set by internal timer.
// [R3] Pointer reads reach flash when high nibble is 0111; unimplemented reads zero.
// [R4] Pointer path never writes or erases flash.
// [R5] Protect configuration low blocks all register writes and erases; the code blocks only flash writes and erases.
// [R6] Read start with region select high stalls; data valid next cycle.
// [R7] Low data byte holds read value until next read or software write.
// [R8] Hardware clears read start when the read completes.
// [R9] Software writes 55h, then AAh, then sets write start.
// [R10] Broken unlock timing discards the requested write.
// [R11] Write start stalls the processor until the operation ends.
// [R12] Software disables interrupts around the unlock sequence.
// [R13] Erase is a normal byte write of all ones.
// [R14] Program/erase enable clear inhibits all program and erase cycles.
// [R15] Protected address at write start clears write start, no write.
// [R16] Completion clears write start, sets completion flag, interrupt if enabled.
// [R17] Write error flag on protected write, reset mid-write, broken unlock.
// [R18] Software may set write error; only software clears it.
// [R19] Region select bit 6: one data flash and info areas, zero program flash; the code has no program flash and ignores read and write starts with it zero.
// [R20] Latch-only with erase off only loads a latch; ignored with erase on.
// [R21] Row erase enable erases a 32-word row containing the address.
// [R22] Address bits 14:0 read/write reset zero; bit 15 undefined while writing.
// [R23] Unlock register is write-only, reset zero, feeds the pattern detector.
// [R24] Writing zero to write start during a write has no effect.
// [R25] Programming length is a parameter; stall and busy stay high throughout.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_ctrl_defs.svh"

module nvm_ctrl
    import nvm_ctrl_pkg::*;
#(
    parameter int DFM_DEPTH   = 128,
    parameter int PROG_CYCLES = `PROG_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        data_flash_protect_config,
    input  wire logic        self_write_lost,
    input  wire ptr_req_t    ptr_req,
    output ptr_rsp_t         ptr_rsp,
    output logic             cpu_stall,
    output logic             nvm_busy,
    output logic             nvm_irq
);
    localparam int AW = $clog2(DFM_DEPTH);

    logic [1:0]    rst_sync_reg;
    wire           rst_n = rst_sync_reg[1];
    logic          prot_meta_reg, prot_reg, lost_meta_reg, lost_reg;

    logic [7:0]    dfm_mem [DFM_DEPTH];
    logic [15:0]   flash_address_reg;
    logic [7:0]    flash_data_low_reg, flash_data_high_reg;
    control_t      ctl_reg;
    logic          completion_flag_reg, completion_irq_enable_reg;
    nvm_state_t    state_reg;
    unlock_state_t ul_reg;
    logic [2:0]    ul_cnt_reg;
    logic [31:0]   prog_cnt_reg;
    logic          aw_reg, awr_reg;
    logic [13:0]   aaddr_reg;

    // Strap and loss inputs come from outside this clock domain
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prot_meta_reg <= 1'b0;
            prot_reg      <= 1'b0;
            lost_meta_reg <= 1'b0;
            lost_reg      <= 1'b0;
        end else begin
            prot_meta_reg <= data_flash_protect_config;
            prot_reg      <= prot_meta_reg;
            lost_meta_reg <= self_write_lost;
            lost_reg      <= lost_meta_reg;
        end
    end

    function automatic logic in_dfm(input logic [15:0] a);
        // Bit 15 is not stored; region select supplies it, so page 0x70 maps to 0xf0
        return (a[14:8] == 7'(`DFM_REGS_PAGE)) && (a[7:0] < DFM_DEPTH);
    endfunction

    // Bus decode
    wire        wr_cyc   = aw_reg && awr_reg;
    wire [13:0] rd_idx   = haddr[15:2];
    wire        sel_addr = wr_cyc && aaddr_reg == `ADDR_FLASH_ADDRESS;
    wire        sel_data = wr_cyc && aaddr_reg == `ADDR_FLASH_DATA;
    wire        sel_ctl  = wr_cyc && aaddr_reg == `ADDR_FLASH_CONTROL;
    wire        sel_ul   = wr_cyc && aaddr_reg == `ADDR_UNLOCK_REG;
    wire        sel_st   = wr_cyc && aaddr_reg == `ADDR_FLASH_STATUS;
    wire        take     = hsel && hready && htrans[1];

    wire        idle       = state_reg == ST_IDLE;
    wire        rd_start   = sel_ctl && hwdata[`BIT_RD] && idle && ctl_reg.regs;                // [R6]
    wire        wr_request = sel_ctl && hwdata[`BIT_WR] && idle;
    wire        unlocked   = ul_reg == UL_ARMED;                                              // [R9]
    wire        addr_ok    = in_dfm(flash_address_reg);
    wire        protected_hit = !prot_reg || !addr_ok;                                        // [R5]
    wire        wr_go      = wr_request && unlocked && ctl_reg.program_erase_enable && ctl_reg.regs && !protected_hit; // [R14]
    wire        wr_denied  = wr_request && unlocked && ctl_reg.program_erase_enable && ctl_reg.regs && protected_hit;  // [R15]
    wire        ul_broken  = (wr_request && !unlocked) || (ul_reg != UL_NONE && ul_cnt_reg == 3'd0);   // [R10]
    wire        prog_done  = state_reg == ST_PROG && prog_cnt_reg == 32'd0;
    wire [AW-1:0] idx      = flash_address_reg[AW-1:0];                                        // [R1]
    // Pointer path decode: read only, no write port at all
    wire [AW-1:0] pidx     = ptr_req.addr[AW-1:0];
    wire        ptr_hit    = ptr_req.addr[15:12] == `DFM_NIBBLE && ptr_req.addr[11:0] < DFM_DEPTH; // [R3]

    // AHB address phase capture; zero wait states
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_reg    <= 1'b0;
            awr_reg   <= 1'b0;
            aaddr_reg <= 14'h0000;
            hrdata    <= 32'h0000_0000;
        end else begin
            aw_reg    <= take;
            awr_reg   <= hwrite;
            aaddr_reg <= haddr[15:2];
            if (take && !hwrite) begin
                unique case (rd_idx)
                    `ADDR_FLASH_ADDRESS: hrdata <= {16'h0000, state_reg == ST_PROG, flash_address_reg[14:0]}; // [R22]
                    `ADDR_FLASH_DATA:    hrdata <= {16'h0000, flash_data_high_reg, flash_data_low_reg};
                    `ADDR_FLASH_CONTROL: hrdata <= {25'h0, ctl_reg};
                    `ADDR_FLASH_STATUS:  hrdata <= {30'h0, completion_irq_enable_reg, completion_flag_reg};
                    default:             hrdata <= 32'h0000_0000; // Unlock register reads zero [R23]
                endcase
            end
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Unlock detector: each step must follow within a short window
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ul_reg     <= UL_NONE;
            ul_cnt_reg <= 3'd0;
        end else if (sel_ul) begin
            ul_cnt_reg <= 3'(`UNLOCK_WINDOW);
            unique case (ul_reg)
                UL_NONE:  ul_reg <= (hwdata[7:0] == `UNLOCK_FIRST) ? UL_FIRST : UL_NONE;  // [R23]
                UL_FIRST: ul_reg <= (hwdata[7:0] == `UNLOCK_SECOND) ? UL_ARMED : UL_NONE;
                UL_ARMED: ul_reg <= (hwdata[7:0] == `UNLOCK_FIRST) ? UL_FIRST : UL_NONE;
                default:  ul_reg <= UL_NONE;
            endcase
        end else if (sel_ctl || ul_cnt_reg == 3'd0) begin
            ul_reg     <= UL_NONE;   // A control write or an expired window consumes the arming [R10]
            ul_cnt_reg <= 3'd0;
        end else if (ul_reg != UL_NONE) begin
            ul_cnt_reg <= ul_cnt_reg - 3'd1;
        end
    end

    // Operation sequencer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= ST_IDLE;
            prog_cnt_reg <= 32'd0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (rd_start) begin
                        state_reg <= ST_READ;
                    end else if (wr_go && !(ctl_reg.latch_only && !ctl_reg.free)) begin
                        state_reg    <= ST_PROG;                      // [R2] [R11]
                        prog_cnt_reg <= PROG_CYCLES - 1;              // [R25]
                    end
                end
                ST_READ: state_reg <= ST_IDLE;
                ST_PROG: begin
                    if (prog_cnt_reg == 32'd0) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        prog_cnt_reg <= prog_cnt_reg - 32'd1;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Registers: address, data, control and status
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_address_reg   <= `RESET_ADDRESS;
            flash_data_low_reg  <= 8'h00;
            flash_data_high_reg <= 8'h00;
            ctl_reg             <= control_t'(`RESET_CONTROL);
            completion_flag_reg           <= 1'b0;
            completion_irq_enable_reg           <= 1'b0;
        end else begin
            if (sel_addr && state_reg != ST_PROG) begin
                flash_address_reg <= {1'b0, hwdata[14:0]};            // [R22]
            end
            if (state_reg == ST_READ) begin
                flash_data_low_reg  <= addr_ok ? dfm_mem[idx] : 8'h00; // [R6] [R7] [R19]
                flash_data_high_reg <= 8'h00;
            end else if (sel_data) begin
                flash_data_low_reg  <= hwdata[7:0];                   // [R7]
                flash_data_high_reg <= {2'b00, hwdata[13:8]};
            end
            if (sel_ctl) begin
                ctl_reg.regs  <= hwdata[`BIT_REGS];                   // [R19]
                ctl_reg.latch_only  <= hwdata[`BIT_LATCH_ONLY];                   // [R20]
                ctl_reg.free  <= hwdata[`BIT_FREE];                   // [R21]
                ctl_reg.program_erase_enable  <= hwdata[`BIT_PROGRAM_ERASE_ENABLE];
                ctl_reg.rd    <= rd_start;
                ctl_reg.wr    <= ctl_reg.wr | (wr_go && !(ctl_reg.latch_only && !ctl_reg.free)); // [R24]
            end
            if (state_reg == ST_READ) begin
                ctl_reg.rd <= 1'b0;                                   // [R8]
            end
            if (prog_done) begin
                ctl_reg.wr <= 1'b0;                                   // [R16]
            end
            // Set wins over the software clear
            ctl_reg.write_error_flag <= wr_denied || ul_broken || lost_reg ||
                             (sel_ctl ? hwdata[`BIT_WRITE_ERROR_FLAG] : ctl_reg.write_error_flag); // [R17] [R18]
            if (sel_st) begin
                completion_irq_enable_reg <= hwdata[`BIT_COMPLETION_IRQ_ENABLE];
            end
            completion_flag_reg <= prog_done || (sel_st ? hwdata[`BIT_COMPLETION_FLAG] : completion_flag_reg); // [R16]
        end
    end

    // Array storage; erase-before-write is implicit in storing the new byte
    always_ff @(posedge sys_clk) begin
        if (prog_done && !ctl_reg.free) begin
            dfm_mem[idx] <= flash_data_low_reg;                       // [R1] [R2] [R13]
        end else if (prog_done) begin
            for (int i = 0; i < 32; i++) begin
                if (in_dfm({flash_address_reg[15:5], 5'(i)})) begin
                    dfm_mem[{flash_address_reg[AW-1:5], 5'(i)}] <= 8'hff; // [R21]
                end
            end
        end
    end

    // Outputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_rsp   <= '0;
            cpu_stall <= 1'b0;
            nvm_busy  <= 1'b0;
            nvm_irq   <= 1'b0;
        end else begin
            ptr_rsp.valid <= ptr_req.valid;
            ptr_rsp.data  <= ptr_hit ? dfm_mem[pidx] : 8'h00;         // [R3] [R4]
            cpu_stall     <= rd_start || (wr_go && !(ctl_reg.latch_only && !ctl_reg.free)) ||
                             (state_reg == ST_PROG && !prog_done);    // [R11] [R25]
            nvm_busy      <= (state_reg == ST_PROG && !prog_done) || (wr_go && !(ctl_reg.latch_only && !ctl_reg.free));
            nvm_irq       <= (prog_done || completion_flag_reg) && completion_irq_enable_reg;   // [R16]
        end
    end

    chk_read_clears_rd: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_start |=> ##1 !ctl_reg.rd) else $error("read start not cleared"); // [R8]
    chk_done_sets_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        prog_done |=> completion_flag_reg && !ctl_reg.wr) else $error("completion not flagged"); // [R16]
    chk_denied_error: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_denied |=> ctl_reg.write_error_flag && state_reg == ST_IDLE) else $error("protected write not refused"); // [R15]
    chk_program_erase_enable_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_reg == ST_IDLE && !ctl_reg.program_erase_enable) |=> state_reg != ST_PROG) else $error("write without enable"); // [R14]
    chk_protect_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_reg == ST_IDLE && !prot_reg) |=> state_reg != ST_PROG) else $error("write while protected"); // [R5]
    chk_unlock_need: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_request && !unlocked) |=> state_reg == ST_IDLE && ctl_reg.write_error_flag) else $error("unlock bypassed"); // [R10]
    chk_stall_prog: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_reg == ST_PROG && !prog_done) |=> cpu_stall && nvm_busy) else $error("stall dropped"); // [R25]
    chk_error_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ctl_reg.write_error_flag && !sel_ctl) |=> ctl_reg.write_error_flag) else $error("error flag lost"); // [R18]
endmodule
`default_nettype wire

// [cpu_model.sv]
/*
 * CPU-side partner of the flash controller: AHB-Lite single word transfers, unlock sequence.
 * Assumes hready is the slave's hreadyout and each task is entered just after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
`include "nvm_ctrl_defs.svh"
module cpu_model (
    input  wire logic        sys_clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    input  wire logic        cpu_stall,
    input  wire logic        nvm_busy,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [13:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {16'h0000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic reg_wr(input logic [13:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        xfer(1'b1, idx, wd, d);
    endtask
    task automatic reg_rd(input logic [13:0] idx, output logic [31:0] d);
        xfer(1'b0, idx, 32'h0, d);
    endtask
    // A stalled core issues nothing; sampled on falling edges to keep clear of the update edge
    task automatic wait_free(output int n);
        n = 0;
        repeat (2) begin
            @(negedge sys_clk);
            n += int'(nvm_busy === 1'b1);
        end
        while (cpu_stall === 1'b1 || nvm_busy === 1'b1) begin
            @(negedge sys_clk);
            n += int'(nvm_busy === 1'b1);
        end
        @(posedge sys_clk);
    endtask
    // No interrupts in this core, so the steps run back to back unless gap breaks them
    task automatic unlock_go(input logic [7:0] ctl, input int gap, output int n);
        reg_wr(`ADDR_UNLOCK_REG, {24'h0, `UNLOCK_FIRST});
        repeat (gap) @(posedge sys_clk);
        reg_wr(`ADDR_UNLOCK_REG, {24'h0, `UNLOCK_SECOND});
        reg_wr(`ADDR_FLASH_CONTROL, {24'h0, ctl});
        wait_free(n);
    endtask
    task automatic flash_write(input logic [7:0] idx, input logic [7:0] b, input logic [7:0] ctl,
                               input int gap, output int n);
        reg_wr(`ADDR_FLASH_ADDRESS, {16'h0, `DFM_REGS_PAGE, idx});
        reg_wr(`ADDR_FLASH_DATA, {24'h0, b});
        reg_wr(`ADDR_FLASH_CONTROL, {24'h0, ctl & 8'hfd});
        unlock_go(ctl, gap, n);
    endtask
    task automatic flash_read(input logic [7:0] idx, output logic [7:0] b);
        logic [31:0] d;
        int          n;
        reg_wr(`ADDR_FLASH_ADDRESS, {16'h0, `DFM_REGS_PAGE, idx});
        reg_wr(`ADDR_FLASH_CONTROL, 32'h41);
        wait_free(n);
        reg_rd(`ADDR_FLASH_DATA, d);
        b = d[7:0];
    endtask
endmodule
`default_nettype wire

// [data_flash_nvm_controller_test.sv]
/*
 * Self-checking bench of the data flash controller, driven through the CPU partner model.
 * Assumes the design package, defines header and partner model compile first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "nvm_ctrl_defs.svh"
module data_flash_nvm_controller_test;
    import nvm_ctrl_pkg::*;
    localparam int          PROG  = 20;
    localparam logic [13:0] A_ADR = `ADDR_FLASH_ADDRESS;
    localparam logic [13:0] A_DAT = `ADDR_FLASH_DATA;
    localparam logic [13:0] A_CTL = `ADDR_FLASH_CONTROL;
    localparam logic [13:0] A_STS = `ADDR_FLASH_STATUS;
    logic        sys_clk, resetn, hsel, hwrite, hreadyout, hresp;
    logic        data_flash_protect_config, self_write_lost, cpu_stall, nvm_busy, nvm_irq;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  b;
    ptr_req_t    ptr_req;
    ptr_rsp_t    ptr_rsp;
    int          n_fail, n_tests, n;
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    nvm_ctrl #(.PROG_CYCLES(PROG)) dut (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .data_flash_protect_config(data_flash_protect_config), .self_write_lost(self_write_lost),
        .ptr_req(ptr_req), .ptr_rsp(ptr_rsp), .cpu_stall(cpu_stall), .nvm_busy(nvm_busy), .nvm_irq(nvm_irq));
    cpu_model cpu (.sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .cpu_stall(cpu_stall),
        .nvm_busy(nvm_busy), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_range(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask
    // Outputs are looked at on the falling edge, well away from the update edge
    task automatic chk_irq(input logic exp);
        @(posedge sys_clk);
        @(negedge sys_clk);
        check({31'h0, nvm_irq}, {31'h0, exp});
        @(posedge sys_clk);
    endtask
    task automatic ptr_chk(input logic [15:0] a, input logic [7:0] exp);
        ptr_req <= '{valid: 1'b1, addr: a};
        @(posedge sys_clk);
        ptr_req <= '{valid: 1'b0, addr: a};
        @(negedge sys_clk);
        if (ptr_rsp.valid !== 1'b1) @(negedge sys_clk);
        check({23'h0, ptr_rsp}, {23'h0, 1'b1, exp});
        @(posedge sys_clk);
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        $display("BAD t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        complete_run();
    end
    initial begin
        resetn = 1'b0;
        data_flash_protect_config = 1'b1;
        self_write_lost = 1'b0;
        ptr_req = '0;
        n_fail = 0;
        n_tests = 0;
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (5) @(posedge sys_clk);
        cpu.reg_rd(A_ADR, d); check(d, 32'h0);
        cpu.reg_rd(A_CTL, d); check(d, 32'h0);
        cpu.reg_rd(`ADDR_UNLOCK_REG, d); check(d, 32'h0);
        cpu.reg_rd(14'h0123, d); check(d, 32'h0);
        cpu.reg_wr(A_ADR, 32'h7fff); cpu.reg_rd(A_ADR, d); check(d, 32'h7fff);
        $display("test reset done");
        cpu.flash_write(8'h05, 8'h3c, 8'h46, 0, n); check_range(n, PROG, PROG + 2);
        cpu.reg_rd(A_CTL, d); check(d, 32'h44);
        cpu.reg_rd(A_STS, d); check(d, 32'h1);
        chk_irq(1'b0);
        cpu.reg_wr(A_STS, 32'h3); chk_irq(1'b1);
        cpu.reg_wr(A_STS, 32'h2); chk_irq(1'b0);
        cpu.reg_wr(A_DAT, 32'h0); cpu.flash_read(8'h05, b); check({24'h0, b}, 32'h3c);
        cpu.reg_rd(A_CTL, d); check(d, 32'h40);
        repeat (10) @(posedge sys_clk);
        cpu.reg_rd(A_DAT, d); check(d & 32'hff, 32'h3c);
        cpu.reg_wr(A_DAT, 32'h5a); cpu.reg_rd(A_DAT, d); check(d & 32'hff, 32'h5a);
        ptr_chk(16'h7005, 8'h3c);
        $display("test write read done");
        cpu.flash_write(8'h05, 8'hff, 8'h46, 0, n);
        cpu.flash_read(8'h05, b); check({24'h0, b}, 32'hff);
        ptr_chk(16'h70c8, 8'h00);
        ptr_chk(16'h6005, 8'h00);
        cpu.flash_write(8'h06, 8'h12, 8'h46, 0, n);
        cpu.flash_write(8'h05, 8'h77, 8'h66, 0, n); check_range(n, 0, 0);
        cpu.flash_read(8'h05, b); check({24'h0, b}, 32'hff);
        cpu.flash_read(8'h06, b); check({24'h0, b}, 32'h12);
        cpu.flash_write(8'h05, 8'h00, 8'h56, 0, n); check_range(n, PROG, PROG + 2);
        cpu.flash_read(8'h06, b); check({24'h0, b}, 32'hff);
        $display("test erase done");
        cpu.flash_write(8'h05, 8'h11, 8'h42, 0, n);
        cpu.flash_read(8'h05, b); check({24'h0, b}, 32'hff);
        data_flash_protect_config <= 1'b0;
        repeat (4) @(posedge sys_clk);
        cpu.flash_write(8'h05, 8'h22, 8'h46, 0, n);
        cpu.reg_rd(A_CTL, d); check(d, 32'h4c);
        cpu.flash_read(8'h05, b); check({24'h0, b}, 32'hff);
        data_flash_protect_config <= 1'b1;
        cpu.reg_wr(A_CTL, 32'h40); cpu.reg_rd(A_CTL, d); check(d, 32'h40);
        cpu.flash_write(8'h05, 8'h33, 8'h46, 8, n);
        cpu.reg_rd(A_CTL, d); check(d & 32'h0a, 32'h08);
        cpu.flash_read(8'h05, b); check({24'h0, b}, 32'hff);
        cpu.reg_wr(A_CTL, 32'h48);
        repeat (10) @(posedge sys_clk);
        cpu.reg_rd(A_CTL, d); check(d, 32'h48);
        cpu.reg_wr(A_CTL, 32'h40);
        self_write_lost <= 1'b1;
        repeat (2) @(posedge sys_clk);
        self_write_lost <= 1'b0;
        repeat (4) @(posedge sys_clk);
        cpu.reg_rd(A_CTL, d); check(d, 32'h48);
        $display("test faults done");
        complete_run();
    end
endmodule
`default_nettype wire
